//--- inc/ettc_pkg.sv
package ettc_pkg;

  // ==========================================================================
  // Widths and limits
  // ==========================================================================
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned CS_W    = 3;
  localparam int unsigned CTRL_W  = 4;
  localparam int unsigned FLAG_W  = 3;
  localparam int unsigned PRESC_W = 10;

  localparam logic [CNT_W-1:0] CNT_MAX    = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
  localparam logic [CNT_W-1:0] CNT_STEP   = 8'h01;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned CTRL_CTC_BIT = 3;
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam int unsigned FLAG_CMA_BIT = 1;
  localparam int unsigned FLAG_CMB_BIT = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
  localparam logic [CNT_W-1:0]   CMP_RST   = 8'h00;
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 4'h0;
  localparam logic [FLAG_W-1:0]  FLAG_RST  = 3'h0;
  localparam logic [FLAG_W-1:0]  MASK_RST  = 3'h0;
  localparam logic [PRESC_W-1:0] PRESC_RST = 10'h000;

  // ==========================================================================
  // Clock select codes and prescaler terminal counts
  // ==========================================================================
  typedef enum logic [CS_W-1:0] {
    CS_STOP   = 3'b000,
    CS_DIV1   = 3'b001,
    CS_DIV8   = 3'b010,
    CS_DIV64  = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1K  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } ettc_cs_e;

  localparam logic [PRESC_W-1:0] TERM_DIV8   = 10'h007;
  localparam logic [PRESC_W-1:0] TERM_DIV64  = 10'h03F;
  localparam logic [PRESC_W-1:0] TERM_DIV256 = 10'h0FF;
  localparam logic [PRESC_W-1:0] TERM_DIV1K  = 10'h3FF;

endpackage

//--- inc/ettc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the clock selection into the tick generator and the tick back.
interface ettc_tick_if;
  import ettc_pkg::*;
  logic [CS_W-1:0] clock_select;
  logic            gated;
  logic            tick;
  modport gen  (input clock_select, input gated, output tick);
  modport core (output clock_select, output gated, input tick);
endinterface

`default_nettype wire

//--- hw/ettc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module ettc_tick_gen
  import ettc_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic external_count_pin_i,
  ettc_tick_if.gen  tif
);

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic               sync1;
    logic               sync2;
    logic               prev;
    logic               tick;
  } ettc_tick_s;

  ettc_tick_s s_q;
  ettc_tick_s s_d;
  logic       raw;

  // ==========================================================================
  // Source and edge selection
  // ==========================================================================
  // The prescaler runs freely so that changing the divisor needs no restart;
  // the cost is a first tick up to one full period early.
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = external_count_pin_i;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.presc = tif.gated ? PRESC_RST : s_q.presc + 10'h001;
    case (ettc_cs_e'(tif.clock_select))
      CS_STOP:     raw = 1'b0;
      CS_DIV1:     raw = 1'b1;
      CS_DIV8:     raw = (s_q.presc[2:0] == TERM_DIV8[2:0]);
      CS_DIV64:    raw = (s_q.presc[5:0] == TERM_DIV64[5:0]);
      CS_DIV256:   raw = (s_q.presc[7:0] == TERM_DIV256[7:0]);
      CS_DIV1K:    raw = (s_q.presc == TERM_DIV1K);
      CS_EXT_FALL: raw = s_q.prev & ~s_q.sync2;
      CS_EXT_RISE: raw = ~s_q.prev & s_q.sync2;
      default:     raw = 1'b0;
    endcase
    s_d.tick = raw & ~tif.gated;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{presc: PRESC_RST, sync1: 1'b0, sync2: 1'b0, prev: 1'b0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.tick = s_q.tick;

endmodule // ettc_tick_gen

`default_nettype wire

//--- hw/ettc_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ettc_timer
  import ettc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              power_gate_bit_i,
  input  wire logic              external_count_pin_i,
  input  wire logic              ctrl_write_i,
  input  wire logic [CTRL_W-1:0] ctrl_wdata_i,
  input  wire logic              count_write_i,
  input  wire logic [CNT_W-1:0]  count_wdata_i,
  input  wire logic              compare_a_write_i,
  input  wire logic [CNT_W-1:0]  compare_a_wdata_i,
  input  wire logic              compare_b_write_i,
  input  wire logic [CNT_W-1:0]  compare_b_wdata_i,
  input  wire logic              mask_write_i,
  input  wire logic [FLAG_W-1:0] mask_wdata_i,
  input  wire logic [FLAG_W-1:0] flag_clear_i,
  output logic [CTRL_W-1:0]      control_register_a_o,
  output logic [CNT_W-1:0]       timer_count_value_o,
  output logic [CNT_W-1:0]       compare_value_a_o,
  output logic [CNT_W-1:0]       compare_value_b_o,
  output logic [FLAG_W-1:0]      interrupt_flag_register_o,
  output logic [FLAG_W-1:0]      interrupt_mask_register_o,
  output logic [FLAG_W-1:0]      irq_o
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  cmp_a;
    logic [CNT_W-1:0]  cmp_b;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] mask;
    logic              block;
    logic [FLAG_W-1:0] irq;
  } ettc_state_s;

  ettc_state_s       s_q;
  ettc_state_s       s_d;
  ettc_tick_if       tif ();
  logic              ctc_mode;
  logic              match_a;
  logic              match_b;
  logic              at_max;
  logic              do_step;
  logic              do_clear;
  logic [FLAG_W-1:0] set_flags;

  // ==========================================================================
  // Tick generation
  // ==========================================================================
  assign tif.clock_select = s_q.ctrl[CS_W-1:0];
  assign tif.gated        = power_gate_bit_i;

  ettc_tick_gen u_tick (
    .clock_i              (clock_i),
    .rst_i                (rst_i),
    .external_count_pin_i (external_count_pin_i),
    .tif                  (tif)
  );

  // ==========================================================================
  // Counter core
  // ==========================================================================
  always_comb begin
    s_d      = s_q;
    ctc_mode = s_q.ctrl[CTRL_CTC_BIT];
    match_a  = (s_q.cnt == s_q.cmp_a);
    match_b  = (s_q.cnt == s_q.cmp_b);
    at_max   = (s_q.cnt == CNT_MAX);
    // In clear-on-match mode compare A is the top; otherwise 0xFF wraps.
    do_clear = tif.tick & ctc_mode & match_a;
    do_step  = tif.tick & ~do_clear;
    set_flags = '0;
    if (tif.tick) begin
      set_flags[FLAG_OVF_BIT] = at_max;
      if (!s_q.block) begin
        set_flags[FLAG_CMA_BIT] = match_a;
        set_flags[FLAG_CMB_BIT] = match_b;
      end
    end
    if (do_clear) begin
      s_d.cnt = CNT_BOTTOM;
    end else if (do_step) begin
      s_d.cnt = s_q.cnt + CNT_STEP;
    end
    if (tif.tick) begin
      s_d.block = 1'b0;
    end
    // A counter write lands last so it wins over the tick and rearms the
    // match blocking, even while the timer is stopped.
    if (count_write_i) begin
      s_d.cnt   = count_wdata_i;
      s_d.block = 1'b1;
    end
    if (compare_a_write_i) begin
      s_d.cmp_a = compare_a_wdata_i;
    end
    if (compare_b_write_i) begin
      s_d.cmp_b = compare_b_wdata_i;
    end
    if (ctrl_write_i) begin
      s_d.ctrl = ctrl_wdata_i;
    end
    if (mask_write_i) begin
      s_d.mask = mask_wdata_i;
    end
    // A flag event in the same cycle as its clear is kept.
    s_d.flags = (s_q.flags & ~flag_clear_i) | set_flags;
    s_d.irq   = s_d.flags & s_d.mask;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{ctrl: CTRL_RST, cnt: CNT_RST, cmp_a: CMP_RST, cmp_b: CMP_RST,
               flags: FLAG_RST, mask: MASK_RST, block: 1'b0, irq: FLAG_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign control_register_a_o      = s_q.ctrl;
  assign timer_count_value_o       = s_q.cnt;
  assign compare_value_a_o         = s_q.cmp_a;
  assign compare_value_b_o         = s_q.cmp_b;
  assign interrupt_flag_register_o = s_q.flags;
  assign interrupt_mask_register_o = s_q.mask;
  assign irq_o                     = s_q.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_wrap_tick;
    tif.tick && !ctc_mode && at_max && !count_write_i;
  endsequence

  sequence s_blocked_tick;
    count_write_i ##1 (tif.tick && !count_write_i && !s_q.flags[FLAG_CMB_BIT]
                       && !flag_clear_i[FLAG_CMB_BIT]);
  endsequence

  stop_no_tick_a: assert property (
    (s_q.ctrl[CS_W-1:0] == CS_STOP || power_gate_bit_i) |=> !tif.tick)
    else $error("tick while stopped or gated");

  hold_no_tick_a: assert property (
    (!tif.tick && !count_write_i) |=> $stable(s_q.cnt))
    else $error("counter moved without tick or write");

  write_wins_a: assert property (
    count_write_i |=> (timer_count_value_o == $past(count_wdata_i)))
    else $error("counter write not stored");

  wrap_overflow_a: assert property (
    s_wrap_tick |=> (timer_count_value_o == CNT_BOTTOM) && interrupt_flag_register_o[FLAG_OVF_BIT])
    else $error("wrap or overflow flag wrong");

  ctc_clear_a: assert property (
    (tif.tick && ctc_mode && match_a && !count_write_i) |=>
      (timer_count_value_o == CNT_BOTTOM) && (interrupt_flag_register_o[FLAG_CMA_BIT] || $past(s_q.block)))
    else $error("clear on compare A missed");

  ovf_any_mode_a: assert property (
    (tif.tick && at_max) |=> interrupt_flag_register_o[FLAG_OVF_BIT])
    else $error("overflow flag missed at maximum");

  match_a_set_a: assert property (
    (tif.tick && match_a && !s_q.block) |=> interrupt_flag_register_o[FLAG_CMA_BIT])
    else $error("compare A flag not set");

  match_b_set_a: assert property (
    (tif.tick && match_b && !s_q.block) |=> interrupt_flag_register_o[FLAG_CMB_BIT])
    else $error("compare B flag not set");

  match_block_a: assert property (
    s_blocked_tick |=> !interrupt_flag_register_o[FLAG_CMB_BIT])
    else $error("match not blocked after write");

  irq_gate_a: assert property (
    irq_o == (interrupt_flag_register_o & interrupt_mask_register_o))
    else $error("interrupt not gated by mask");

  set_wins_a: assert property (
    (tif.tick && at_max && flag_clear_i[FLAG_OVF_BIT]) |=> interrupt_flag_register_o[FLAG_OVF_BIT])
    else $error("overflow lost to clear");

  step_one_a: assert property (
    (tif.tick && !ctc_mode && !at_max && !count_write_i) |=>
      (timer_count_value_o == $past(timer_count_value_o) + CNT_STEP))
    else $error("counter did not step by one");

endmodule // ettc_timer

`default_nettype wire

//--- verification/ettc_testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Bench for the eight-bit timer counter.
module testbench;
  import ettc_pkg::*;

  typedef struct {
    logic [2:0] sel;
    logic [7:0] exp;
  } ettc_note_s;

  logic              clock_i;
  logic              rst_i;
  logic              power_gate_bit_i;
  logic              external_count_pin_i;
  logic              ctrl_write_i;
  logic [CTRL_W-1:0] ctrl_wdata_i;
  logic              count_write_i;
  logic [CNT_W-1:0]  count_wdata_i;
  logic              compare_a_write_i;
  logic [CNT_W-1:0]  compare_a_wdata_i;
  logic              compare_b_write_i;
  logic [CNT_W-1:0]  compare_b_wdata_i;
  logic              mask_write_i;
  logic [FLAG_W-1:0] mask_wdata_i;
  logic [FLAG_W-1:0] flag_clear_i;
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cmpa_q;
  logic [CNT_W-1:0]  cmpb_q;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] mask_q;
  logic [FLAG_W-1:0] irq_q;
  ettc_note_s        notes_q[$];
  ettc_note_s        nt;
  event              note_ev;
  int                mismatches;
  int                samples_checked;
  int                cycles;
  int                divs[4] = '{8, 64, 256, 1024};
  logic [7:0]        r;
  logic [7:0]        v;
  logic [3:0]        c;
  logic [2:0]        m;

  ettc_timer ettc_timer_i (
    .clock_i(clock_i), .rst_i(rst_i), .power_gate_bit_i(power_gate_bit_i),
    .external_count_pin_i(external_count_pin_i), .ctrl_write_i(ctrl_write_i), .ctrl_wdata_i(ctrl_wdata_i),
    .count_write_i(count_write_i), .count_wdata_i(count_wdata_i), .compare_a_write_i(compare_a_write_i),
    .compare_a_wdata_i(compare_a_wdata_i), .compare_b_write_i(compare_b_write_i),
    .compare_b_wdata_i(compare_b_wdata_i), .mask_write_i(mask_write_i), .mask_wdata_i(mask_wdata_i),
    .flag_clear_i(flag_clear_i), .control_register_a_o(ctrl_q), .timer_count_value_o(cnt_q),
    .compare_value_a_o(cmpa_q), .compare_value_b_o(cmpb_q), .interrupt_flag_register_o(flag_q),
    .interrupt_mask_register_o(mask_q), .irq_o(irq_q)
  );

  // ========================================
  // Checking.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] pick(input logic [2:0] s);
    case (s)
      3'h0: return cnt_q;
      3'h1: return {5'h00, flag_q};
      3'h2: return {5'h00, irq_q};
      3'h3: return {4'h0, ctrl_q};
      3'h4: return cmpa_q;
      3'h5: return cmpb_q;
      default: return {5'h00, mask_q};
    endcase
  endfunction

  // The driver runs in the same time step, so the queue is drained whole.
  initial begin
    forever begin
      @(note_ev);
      while (notes_q.size() > 0) begin
        nt = notes_q.pop_front();
        check(pick(nt.sel), nt.exp);
      end
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ========================================
  // Driving.
  task automatic note(input logic [2:0] s, input logic [7:0] e);
    notes_q.push_back('{s, e});
    -> note_ev;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Enables, MSB first: control, count, compare A, compare B, mask.
  task automatic wr(input logic [4:0] en, input logic [3:0] cw, input logic [7:0] n, input logic [7:0] a,
                    input logic [7:0] b, input logic [2:0] mw);
    {ctrl_write_i, count_write_i, compare_a_write_i, compare_b_write_i, mask_write_i} = en;
    ctrl_wdata_i = cw;
    count_wdata_i = n;
    compare_a_wdata_i = a;
    compare_b_wdata_i = b;
    mask_wdata_i = mw;
    cyc(1);
    {ctrl_write_i, count_write_i, compare_a_write_i, compare_b_write_i, mask_write_i} = 5'h00;
  endtask

  // Three cycles so that a tick already in flight cannot leave a flag behind.
  task automatic clr();
    flag_clear_i = 3'h7;
    cyc(3);
    flag_clear_i = 3'h0;
  endtask

  task automatic wait_chg(input logic [7:0] old);
    int k;
    k = 0;
    while (cnt_q === old && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k >= 2000) begin
      mismatches++;
      $display("Error at %0t: counter never moved", $time);
    end
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'h4F4C));
    {rst_i, power_gate_bit_i, external_count_pin_i, flag_clear_i} = 6'h20;
    {ctrl_write_i, count_write_i, compare_a_write_i, compare_b_write_i, mask_write_i} = 5'h00;
    {ctrl_wdata_i, count_wdata_i, compare_a_wdata_i, compare_b_wdata_i, mask_wdata_i} = 31'h0;
    cyc(16);
    rst_i = 1'b0;
    cyc(1);
    for (int i = 0; i < 7; i++) note(3'(i), 8'h00);
    repeat (4) begin
      r = 8'($urandom);
      c = 4'($urandom);
      m = 3'($urandom);
      wr(5'h1F, c, r, ~r, r ^ 8'h5A, m);
      note(3'h0, r);
      note(3'h3, {4'h0, c});
      note(3'h4, ~r);
      note(3'h5, r ^ 8'h5A);
      note(3'h6, {5'h00, m});
      cyc(1);
    end
    wr(5'h10, 4'h0, 8'h00, 8'h00, 8'h00, 3'h0);
    clr();
    note(3'h1, 8'h00);
    wr(5'h1F, 4'h1, 8'hFF, 8'h80, 8'h00, 3'h7);
    wait_chg(8'hFF);
    note(3'h0, 8'h00);
    note(3'h1, 8'h01);
    note(3'h2, 8'h01);
    cyc(1);
    note(3'h0, 8'h01);
    note(3'h1, 8'h05);
    note(3'h2, 8'h05);
    power_gate_bit_i = 1'b1;
    clr();
    wr(5'h08, 4'h0, 8'h40, 8'h00, 8'h00, 3'h0);
    cyc(10);
    note(3'h0, 8'h40);
    power_gate_bit_i = 1'b0;
    wait_chg(8'h40);
    note(3'h0, 8'h41);
    power_gate_bit_i = 1'b1;
    clr();
    wr(5'h1F, 4'h1, 8'h10, 8'h80, 8'h10, 3'h4);
    power_gate_bit_i = 1'b0;
    wait_chg(8'h10);
    note(3'h0, 8'h11);
    note(3'h1, 8'h00);
    wr(5'h08, 4'h1, 8'hC0, 8'h00, 8'h00, 3'h0);
    note(3'h0, 8'hC0);
    power_gate_bit_i = 1'b1;
    clr();
    wr(5'h1F, 4'h9, 8'h00, 8'h03, 8'hF0, 3'h0);
    power_gate_bit_i = 1'b0;
    wait_chg(8'h00);
    note(3'h0, 8'h01);
    cyc(2);
    note(3'h0, 8'h03);
    note(3'h1, 8'h00);
    cyc(1);
    note(3'h0, 8'h00);
    note(3'h1, 8'h02);
    note(3'h2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      power_gate_bit_i = 1'b1;
      wr(5'h18, 4'(i + 2), 8'h00, 8'h00, 8'h00, 3'h0);
      power_gate_bit_i = 1'b0;
      wait_chg(8'h00);
      v = cnt_q;
      cyc(divs[i] - 1);
      note(3'h0, v);
      cyc(1);
      note(3'h0, v + 8'h01);
    end
    for (int i = 6; i < 8; i++) begin
      wr(5'h18, 4'(i), 8'h00, 8'h00, 8'h00, 3'h0);
      external_count_pin_i = 1'b1;
      cyc(8);
      note(3'h0, (i == 7) ? 8'h01 : 8'h00);
      external_count_pin_i = 1'b0;
      cyc(8);
      note(3'h0, 8'h01);
    end
    wr(5'h18, 4'h0, 8'h77, 8'h00, 8'h00, 3'h0);
    cyc(20);
    note(3'h0, 8'h77);
    cyc(1);
    print_verdict();
  end

endmodule // testbench

`default_nettype wire
